// *** cmbm_core.sv ***
// Buffer-mapping core of a CANopen/Modbus gateway, both operating modes.
// Operation
// RL1: Words 0-FFh map to input/holding registers.
// RL2: Master requests one contiguous register run.
// RL3: Supervision adds status/command regions at buffer end.
// RL4: Status region reports each slave's NMT state.
// RL5: Control slot write issues matching NMT command.
// RL6: Two-byte slot per node, 127 nodes.
// RL7: Master reads with 04, writes 06/16.
// RL8: Node regions sit at words 100h-17Eh.
// RL9: Node bytes span 0x200-0x2FD each direction.
// RL10: Low byte node number, high byte state/command.
// RL11: Modbus and CANopen sides run independently.
// RL12: PDO process data, SDO parameter access.
// RL13: Slave mode has two 512-byte buffers.
// RL14: Expedited SDO to buffers, sub-index 0.
// RL15: Objects 2000h-207Fh read four input bytes.
// RL16: Objects 2080h-217Fh read two input bytes.
// RL17: Objects 2180h-237Fh read one input byte.
// RL18: Objects 3000h-307Fh write four output bytes.
// RL19: Objects 3080h-317Fh write two output bytes.
// RL20: Objects 3180h-337Fh write one output byte.
// RL21: Upload 40h on 600h+node, reply 43h on 580h+node.
// RL22: Download 23h acknowledged by 60h, zero data.
// RL23: Bad access answered with SDO abort.
// RL24: Standard NMT state and command codes.
`timescale 1ns/1ps
module cmbm_core #(
   parameter int NODES = cmbm_pkg::NODE_MAX
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [6:0] own_node_id,
   input wire logic supervise_en,
   // Modbus slave side (master mode), word access.
   input wire logic mb_wr,
   input wire logic mb_rd,
   input wire logic mb_holding,
   input wire logic [8:0] mb_addr,
   input wire logic [15:0] mb_wdata,
   output logic [15:0] mb_rdata,
   output logic mb_valid,
   output logic mb_err,
   // CANopen process data in/out of the word buffers (PDO path).
   input wire logic pdo_wr,
   input wire logic [7:0] pdo_waddr,
   input wire logic [15:0] pdo_wdata,
   input wire logic [7:0] pdo_raddr,
   output logic [15:0] pdo_rdata,
   // Slave NMT state reports from the CANopen engine.
   input wire logic st_wr,
   input wire logic [6:0] st_node,
   input wire logic [7:0] st_state,
   output cmbm_pkg::cmbm_nmt_s nmt_cmd,
   output logic nmt_valid,
   // Slave-mode byte buffers: Modbus master fills input, reads output.
   input wire logic in_wr,
   input wire logic [8:0] in_addr,
   input wire logic [7:0] in_wdata,
   input wire logic [8:0] out_raddr,
   output logic [7:0] out_rdata,
   // SDO server.
   input wire cmbm_pkg::cmbm_sdo_s sdo_req,
   input wire logic sdo_req_valid,
   output logic sdo_req_ready,
   output cmbm_pkg::cmbm_sdo_s sdo_rsp,
   output logic sdo_rsp_valid,
   input wire logic sdo_rsp_ready
);
   // ==========================================================
   // Master mode word buffers, indexed by protocol address
   logic [15:0] in_words [0:255];
   logic [15:0] out_words [0:255];
   logic [7:0] node_state [1:NODES];
   logic [7:0] node_cmd [1:NODES];
   logic mb_in_main, mb_in_node;
   logic [6:0] mb_node;
   logic [9:0] mb_byte;

   assign mb_in_main = mb_addr <= cmbm_pkg::WORD_LAST; //RL1
   assign mb_in_node = supervise_en && mb_byte >= cmbm_pkg::NODE_BYTE_FIRST
      && mb_byte <= cmbm_pkg::NODE_BYTE_LAST; //RL3 RL8 RL9
   assign mb_node = 7'(mb_addr - cmbm_pkg::NODE_WORD_FIRST + 9'h001); //RL6
   assign mb_byte = {mb_addr, 1'b0}; //RL9

   // Both sides touch the shared buffers only; neither waits on the other.
   always_ff @(posedge ref_clk) begin //RL11
      if (mb_wr && mb_holding && mb_in_main) begin //RL1
         out_words[mb_addr[7:0]] <= mb_wdata;
      end
      if (pdo_wr) begin //RL12
         in_words[pdo_waddr] <= pdo_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      pdo_rdata <= out_words[pdo_raddr]; //RL12
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mb_rdata <= 16'h0000;
         mb_valid <= 1'b0;
         mb_err <= 1'b0;
      end else begin
         mb_valid <= mb_rd || mb_wr;
         mb_err <= (mb_rd || mb_wr) && !(mb_in_main || mb_in_node);
         if (mb_rd && mb_in_main) begin
            mb_rdata <= mb_holding ? out_words[mb_addr[7:0]] : in_words[mb_addr[7:0]]; //RL1
         end else if (mb_rd && mb_in_node) begin
            mb_rdata <= {mb_holding ? node_cmd[mb_node] : node_state[mb_node],
                         {1'b0, mb_node}}; //RL10 RL4
         end else begin
            mb_rdata <= 16'h0000;
         end
      end
   end

   // ==========================================================
   // Node supervision slots
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 1; i <= NODES; i++) begin
            node_state[i] <= cmbm_pkg::ST_PREOP; //RL24
            node_cmd[i] <= 8'h00;
         end
      end else begin
         if (st_wr && st_node != 7'h00) begin
            node_state[st_node] <= st_state; //RL4
         end
         if (mb_wr && mb_holding && mb_in_node) begin
            node_cmd[mb_node] <= mb_wdata[15:8]; //RL10
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         nmt_cmd <= '0;
         nmt_valid <= 1'b0;
      end else begin
         nmt_valid <= 1'b0;
         if (mb_wr && mb_holding && mb_in_node &&
             (mb_wdata[15:8] == cmbm_pkg::CMD_START || mb_wdata[15:8] == cmbm_pkg::CMD_STOP ||
              mb_wdata[15:8] == cmbm_pkg::CMD_PREOP ||
              mb_wdata[15:8] == cmbm_pkg::CMD_RESET_NODE ||
              mb_wdata[15:8] == cmbm_pkg::CMD_RESET_COMM)) begin //RL5 RL24
            nmt_cmd.node <= mb_node;
            nmt_cmd.cmd <= mb_wdata[15:8];
            nmt_valid <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Slave mode byte buffers, 512 bytes each
   logic [7:0] in_bytes [0:cmbm_pkg::BUF_BYTES-1]; //RL13
   logic [7:0] out_bytes [0:cmbm_pkg::BUF_BYTES-1];

   always_ff @(posedge ref_clk) begin
      if (in_wr) begin
         in_bytes[in_addr] <= in_wdata; //RL13
      end
      out_rdata <= out_bytes[out_raddr];
   end

   // ==========================================================
   // SDO server
   cmbm_pkg::cmbm_sdo_e state;
   cmbm_pkg::cmbm_sdo_s req;
   logic [15:0] off;
   logic [8:0] base;
   logic [2:0] len;
   logic is_in, is_out;

   always_comb begin
      off = 16'h0000;
      base = 9'h000;
      len = 3'd0;
      is_in = 1'b0;
      is_out = 1'b0;
      if (req.index >= cmbm_pkg::OBJ_IN4 && req.index < cmbm_pkg::OBJ_IN2) begin
         off = req.index - cmbm_pkg::OBJ_IN4;
         base = {off[6:0], 2'b00}; //RL15
         len = 3'd4;
         is_in = 1'b1;
      end else if (req.index >= cmbm_pkg::OBJ_IN2 && req.index < cmbm_pkg::OBJ_IN1) begin
         off = req.index - cmbm_pkg::OBJ_IN2;
         base = {off[7:0], 1'b0}; //RL16
         len = 3'd2;
         is_in = 1'b1;
      end else if (req.index >= cmbm_pkg::OBJ_IN1 && req.index < cmbm_pkg::OBJ_IN_END) begin
         off = req.index - cmbm_pkg::OBJ_IN1;
         base = off[8:0]; //RL17
         len = 3'd1;
         is_in = 1'b1;
      end else if (req.index >= cmbm_pkg::OBJ_OUT4 && req.index < cmbm_pkg::OBJ_OUT2) begin
         off = req.index - cmbm_pkg::OBJ_OUT4;
         base = {off[6:0], 2'b00}; //RL18
         len = 3'd4;
         is_out = 1'b1;
      end else if (req.index >= cmbm_pkg::OBJ_OUT2 && req.index < cmbm_pkg::OBJ_OUT1) begin
         off = req.index - cmbm_pkg::OBJ_OUT2;
         base = {off[7:0], 1'b0}; //RL19
         len = 3'd2;
         is_out = 1'b1;
      end else if (req.index >= cmbm_pkg::OBJ_OUT1 && req.index < cmbm_pkg::OBJ_OUT_END) begin
         off = req.index - cmbm_pkg::OBJ_OUT1;
         base = off[8:0]; //RL20
         len = 3'd1;
         is_out = 1'b1;
      end
   end

   assign sdo_req_ready = state == cmbm_pkg::CMBM_IDLE;

   // Object reads return the bytes little-endian in the data field, unused bytes zero.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= cmbm_pkg::CMBM_IDLE;
         req <= '0;
         sdo_rsp <= '0;
         sdo_rsp_valid <= 1'b0;
      end else begin
         case (state)
            cmbm_pkg::CMBM_IDLE: begin
               if (sdo_req_valid && sdo_req.cob_id == cmbm_pkg::COB_SDO_RX + 11'(own_node_id)) begin
                  req <= sdo_req; //RL21
                  state <= cmbm_pkg::CMBM_READ;
               end
            end
            cmbm_pkg::CMBM_READ: begin
               sdo_rsp.cob_id <= cmbm_pkg::COB_SDO_TX + 11'(own_node_id); //RL21
               sdo_rsp.index <= req.index;
               sdo_rsp.sub <= req.sub;
               sdo_rsp.cmd <= cmbm_pkg::SDO_ABORT; //RL23
               sdo_rsp.data <= 32'h00000000;
               if (!is_in && !is_out) begin
                  sdo_rsp.data <= cmbm_pkg::ABORT_NO_OBJ; //RL23
               end else if (req.sub != 8'h00) begin
                  sdo_rsp.data <= cmbm_pkg::ABORT_NO_SUB; //RL14 RL23
               end else if (req.cmd == cmbm_pkg::SDO_UPLOAD_REQ && is_in) begin
                  sdo_rsp.cmd <= cmbm_pkg::SDO_UPLOAD_RSP; //RL21
                  sdo_rsp.data <= {len > 3'd2 ? in_bytes[base + 9'd3] : 8'h00,
                                   len > 3'd2 ? in_bytes[base + 9'd2] : 8'h00,
                                   len > 3'd1 ? in_bytes[base + 9'd1] : 8'h00,
                                   in_bytes[base]};
               end else if (req.cmd == cmbm_pkg::SDO_DOWNLOAD_REQ && is_out) begin
                  sdo_rsp.cmd <= cmbm_pkg::SDO_DOWNLOAD_RSP; //RL22
               end else if (req.cmd == cmbm_pkg::SDO_UPLOAD_REQ) begin
                  sdo_rsp.data <= cmbm_pkg::ABORT_WO; //RL23
               end else if (req.cmd == cmbm_pkg::SDO_DOWNLOAD_REQ) begin
                  sdo_rsp.data <= cmbm_pkg::ABORT_RO; //RL23
               end else begin
                  sdo_rsp.data <= cmbm_pkg::ABORT_CMD;
               end
               sdo_rsp_valid <= 1'b1;
               state <= cmbm_pkg::CMBM_ANSWER;
            end
            cmbm_pkg::CMBM_ANSWER: begin
               if (sdo_rsp_ready) begin
                  sdo_rsp_valid <= 1'b0;
                  state <= cmbm_pkg::CMBM_IDLE;
               end
            end
            default: state <= cmbm_pkg::CMBM_IDLE;
         endcase
      end
   end

   logic sdo_wr_ok;
   assign sdo_wr_ok = state == cmbm_pkg::CMBM_READ && is_out && req.sub == 8'h00
      && req.cmd == cmbm_pkg::SDO_DOWNLOAD_REQ;

   always_ff @(posedge ref_clk) begin
      for (int k = 0; k < 4; k++) begin
         if (sdo_wr_ok && 3'(k) < len) begin
            out_bytes[base + 9'(k)] <= req.data[8*k +: 8]; //RL18 RL19 RL20
         end
      end
   end

   // ==========================================================
   // Checks
   a_sdo_answer_time: assert property (@(posedge ref_clk) disable iff (rst) //RL21
      sdo_req_valid && sdo_req_ready && sdo_req.cob_id == cmbm_pkg::COB_SDO_RX + 11'(own_node_id)
      |-> ##2 sdo_rsp_valid) else $error("SDO answer late.");
   a_sdo_ack_zero: assert property (@(posedge ref_clk) disable iff (rst) //RL22
      sdo_rsp_valid && sdo_rsp.cmd == cmbm_pkg::SDO_DOWNLOAD_RSP |-> sdo_rsp.data == 32'h0)
      else $error("Download ack data not zero.");
   a_sdo_sub_zero: assert property (@(posedge ref_clk) disable iff (rst) //RL14
      sdo_rsp_valid && sdo_rsp.sub != 8'h00 |-> sdo_rsp.cmd == cmbm_pkg::SDO_ABORT)
      else $error("Nonzero sub-index accepted.");
   a_sdo_rsp_cob: assert property (@(posedge ref_clk) disable iff (rst) //RL21
      sdo_rsp_valid |-> sdo_rsp.cob_id == cmbm_pkg::COB_SDO_TX + 11'(own_node_id))
      else $error("Wrong response identifier.");
   a_sdo_ro_abort: assert property (@(posedge ref_clk) disable iff (rst) //RL23
      $rose(sdo_rsp_valid) && $past(req.cmd) == cmbm_pkg::SDO_DOWNLOAD_REQ && $past(is_in)
      |-> sdo_rsp.cmd == cmbm_pkg::SDO_ABORT) else $error("Input object written.");
   a_nmt_from_slot: assert property (@(posedge ref_clk) disable iff (rst) //RL5
      nmt_valid |-> $past(mb_wr) && $past(mb_in_node) && nmt_cmd.cmd == $past(mb_wdata[15:8]))
      else $error("NMT command without slot write.");
   a_nmt_pulse: assert property (@(posedge ref_clk) disable iff (rst) //RL5
      nmt_valid |=> !nmt_valid || $past(mb_wr)) else $error("NMT pulse stuck.");
   a_mb_node_err: assert property (@(posedge ref_clk) disable iff (rst) //RL3
      mb_rd && !supervise_en && mb_addr > cmbm_pkg::WORD_LAST |=> mb_valid && mb_err)
      else $error("Node region open while disabled.");
   a_mb_node_lo: assert property (@(posedge ref_clk) disable iff (rst) //RL10
      mb_rd && mb_in_node |=> mb_rdata[7:0] == {1'b0, $past(mb_node)})
      else $error("Slot low byte not node number.");
   c_upload: cover property (@(posedge ref_clk)
      sdo_rsp_valid && sdo_rsp.cmd == cmbm_pkg::SDO_UPLOAD_RSP);
   c_download: cover property (@(posedge ref_clk)
      sdo_rsp_valid && sdo_rsp.cmd == cmbm_pkg::SDO_DOWNLOAD_RSP);
   c_abort: cover property (@(posedge ref_clk)
      sdo_rsp_valid && sdo_rsp.cmd == cmbm_pkg::SDO_ABORT);
   c_nmt: cover property (@(posedge ref_clk) nmt_valid);
endmodule // cmbm_core

// *** cmbm_pkg.sv ***
// Package with constants and carrier types for the gateway buffer-mapping core.
package cmbm_pkg;
   // ==========================================================
   // Buffer geometry
   localparam int BUF_BYTES = 512;
   localparam int BYTE_AW = 9;
   localparam int WORD_AW = 8;
   localparam logic [8:0] WORD_LAST = 9'h0FF;
   localparam logic [8:0] NODE_WORD_FIRST = 9'h100;
   localparam logic [8:0] NODE_WORD_LAST = 9'h17E;
   localparam logic [9:0] NODE_BYTE_FIRST = 10'h200;
   localparam logic [9:0] NODE_BYTE_LAST = 10'h2FD;
   localparam int NODE_MAX = 127;
   // ==========================================================
   // Object dictionary windows
   localparam logic [15:0] OBJ_IN4 = 16'h2000;
   localparam logic [15:0] OBJ_IN2 = 16'h2080;
   localparam logic [15:0] OBJ_IN1 = 16'h2180;
   localparam logic [15:0] OBJ_IN_END = 16'h2380;
   localparam logic [15:0] OBJ_OUT4 = 16'h3000;
   localparam logic [15:0] OBJ_OUT2 = 16'h3080;
   localparam logic [15:0] OBJ_OUT1 = 16'h3180;
   localparam logic [15:0] OBJ_OUT_END = 16'h3380;
   // ==========================================================
   // SDO command bytes and identifiers
   localparam logic [7:0] SDO_UPLOAD_REQ = 8'h40;
   localparam logic [7:0] SDO_UPLOAD_RSP = 8'h43;
   localparam logic [7:0] SDO_DOWNLOAD_REQ = 8'h23;
   localparam logic [7:0] SDO_DOWNLOAD_RSP = 8'h60;
   localparam logic [7:0] SDO_ABORT = 8'h80;
   localparam logic [31:0] ABORT_NO_OBJ = 32'h06020000;
   localparam logic [31:0] ABORT_WO = 32'h06010001;
   localparam logic [31:0] ABORT_RO = 32'h06010002;
   localparam logic [31:0] ABORT_NO_SUB = 32'h06090011;
   localparam logic [31:0] ABORT_CMD = 32'h05040001;
   localparam logic [10:0] COB_SDO_RX = 11'h600;
   localparam logic [10:0] COB_SDO_TX = 11'h580;
   // ==========================================================
   // Standard NMT state and command codes
   localparam logic [7:0] ST_STOPPED = 8'h04;
   localparam logic [7:0] ST_OPERATIONAL = 8'h05;
   localparam logic [7:0] ST_PREOP = 8'h7F;
   localparam logic [7:0] CMD_START = 8'h01;
   localparam logic [7:0] CMD_STOP = 8'h02;
   localparam logic [7:0] CMD_PREOP = 8'h80;
   localparam logic [7:0] CMD_RESET_NODE = 8'h81;
   localparam logic [7:0] CMD_RESET_COMM = 8'h82;

   typedef struct packed {
      logic [10:0] cob_id;
      logic [7:0] cmd;
      logic [15:0] index;
      logic [7:0] sub;
      logic [31:0] data;
   } cmbm_sdo_s;

   typedef struct packed {
      logic [6:0] node;
      logic [7:0] cmd;
   } cmbm_nmt_s;

   typedef enum logic [1:0] {CMBM_IDLE, CMBM_READ, CMBM_ANSWER} cmbm_sdo_e;
endpackage

// *** cmbm_sdo_client.sv ***
// Partner model of the CANopen SDO client that talks to the gateway's server.
`timescale 1ns/1ps
module cmbm_sdo_client (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic start,
   input wire cmbm_pkg::cmbm_sdo_s req_in,
   input wire logic [3:0] delay,
   output cmbm_pkg::cmbm_sdo_s sdo_req,
   output logic sdo_req_valid,
   input wire logic sdo_req_ready,
   input wire cmbm_pkg::cmbm_sdo_s sdo_rsp,
   input wire logic sdo_rsp_valid,
   output logic sdo_rsp_ready,
   output cmbm_pkg::cmbm_sdo_s rsp_seen,
   output logic done
);
   logic waiting;
   logic [3:0] cnt;
   // ==========================================================
   // Request side
   // Once taken, the request lines show their inverse so a late sample cannot pass.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sdo_req_valid <= 1'b0;
         sdo_req <= '0;
         waiting <= 1'b0;
      end else if (sdo_req_valid && sdo_req_ready) begin
         sdo_req_valid <= 1'b0;
         sdo_req <= ~sdo_req;
         waiting <= 1'b1;
      end else if (sdo_rsp_ready && sdo_rsp_valid) begin
         waiting <= 1'b0;
      end else if (start && !sdo_req_valid && !waiting) begin
         sdo_req <= req_in;
         sdo_req_valid <= 1'b1;
      end
   end
   // ==========================================================
   // Response side
   // The answer is taken after a chosen number of stall cycles.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sdo_rsp_ready <= 1'b0;
         cnt <= '0;
         done <= 1'b0;
         rsp_seen <= '0;
      end else begin
         done <= 1'b0;
         if (sdo_rsp_ready && sdo_rsp_valid) begin
            rsp_seen <= sdo_rsp;
            sdo_rsp_ready <= 1'b0;
            cnt <= '0;
            done <= 1'b1;
         end else if (waiting && sdo_rsp_valid) begin
            cnt <= cnt + 4'h1;
            sdo_rsp_ready <= (cnt >= delay);
         end
      end
   end
endmodule // cmbm_sdo_client

// *** test_canopen_modbus_buffer_map.sv ***
// Self-checking testbench of the gateway buffer-mapping core.
`timescale 1ns/1ps
module test_canopen_modbus_buffer_map;
   localparam logic [6:0] NODE_ID = 7'h05;
   logic ref_clk, rst, supervise_en, mb_wr, mb_rd, mb_holding, mb_valid, mb_err;
   logic [8:0] mb_addr, in_addr, out_raddr;
   logic [15:0] mb_wdata, mb_rdata, pdo_wdata, pdo_rdata;
   logic pdo_wr, st_wr, nmt_valid, in_wr, start, done;
   logic sdo_req_valid, sdo_req_ready, sdo_rsp_valid, sdo_rsp_ready;
   logic [7:0] pdo_waddr, pdo_raddr, st_state, in_wdata, out_rdata;
   logic [6:0] st_node;
   logic [3:0] delay;
   cmbm_pkg::cmbm_nmt_s nmt_cmd;
   cmbm_pkg::cmbm_sdo_s sdo_req, sdo_rsp, req_in, rsp_seen;
   int failures = 0;
   int checks = 0;
   cmbm_core uut (.ref_clk(ref_clk), .rst(rst), .own_node_id(NODE_ID),
      .supervise_en(supervise_en), .mb_wr(mb_wr), .mb_rd(mb_rd), .mb_holding(mb_holding),
      .mb_addr(mb_addr), .mb_wdata(mb_wdata), .mb_rdata(mb_rdata), .mb_valid(mb_valid),
      .mb_err(mb_err), .pdo_wr(pdo_wr), .pdo_waddr(pdo_waddr), .pdo_wdata(pdo_wdata),
      .pdo_raddr(pdo_raddr), .pdo_rdata(pdo_rdata), .st_wr(st_wr), .st_node(st_node),
      .st_state(st_state), .nmt_cmd(nmt_cmd), .nmt_valid(nmt_valid), .in_wr(in_wr),
      .in_addr(in_addr), .in_wdata(in_wdata), .out_raddr(out_raddr), .out_rdata(out_rdata),
      .sdo_req(sdo_req), .sdo_req_valid(sdo_req_valid), .sdo_req_ready(sdo_req_ready),
      .sdo_rsp(sdo_rsp), .sdo_rsp_valid(sdo_rsp_valid), .sdo_rsp_ready(sdo_rsp_ready));
   cmbm_sdo_client client (.ref_clk(ref_clk), .rst(rst), .start(start), .req_in(req_in),
      .delay(delay), .sdo_req(sdo_req), .sdo_req_valid(sdo_req_valid),
      .sdo_req_ready(sdo_req_ready), .sdo_rsp(sdo_rsp), .sdo_rsp_valid(sdo_rsp_valid),
      .sdo_rsp_ready(sdo_rsp_ready), .rsp_seen(rsp_seen), .done(done));
   // ==========================================================
   // Helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Returns one settled time step after the edge that raises mb_valid.
   task automatic mb_acc(input logic wr, input logic hold, input logic [8:0] a,
         input logic [15:0] d);
      @(posedge ref_clk);
      mb_wr <= wr;
      mb_rd <= !wr;
      mb_holding <= hold;
      mb_addr <= a;
      mb_wdata <= d;
      @(posedge ref_clk);
      mb_wr <= 1'b0;
      mb_rd <= 1'b0;
      #1;
      check("mb_valid", mb_valid, 1'b1);
   endtask
   task automatic sdo(input logic [7:0] c, input logic [15:0] ix, input logic [7:0] sb,
         input logic [31:0] d, input logic [3:0] dl, input logic [7:0] ec,
         input logic [31:0] ed);
      int n;
      @(posedge ref_clk);
      req_in <= '{cob_id: cmbm_pkg::COB_SDO_RX + {4'h0, NODE_ID}, cmd: c, index: ix,
         sub: sb, data: d};
      delay <= dl;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 40) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check("sdo answered", done, 1'b1);
      check("sdo idle", sdo_req_ready, 1'b1);
      check("sdo cob", rsp_seen.cob_id, cmbm_pkg::COB_SDO_TX + {4'h0, NODE_ID});
      check("sdo cmd", rsp_seen.cmd, ec);
      check("sdo index", rsp_seen.index, ix);
      check("sdo sub", rsp_seen.sub, sb);
      check("sdo data", rsp_seen.data, ed);
   endtask
   task automatic in_byte(input logic [8:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      in_wr <= 1'b1;
      in_addr <= a;
      in_wdata <= d;
      @(posedge ref_clk);
      in_wr <= 1'b0;
   endtask
   task automatic node_state(input logic [6:0] nd, input logic [7:0] s);
      @(posedge ref_clk);
      st_wr <= 1'b1;
      st_node <= nd;
      st_state <= s;
      @(posedge ref_clk);
      st_wr <= 1'b0;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_words();
      @(posedge ref_clk);
      pdo_wr <= 1'b1;
      pdo_waddr <= 8'hFF;
      pdo_wdata <= 16'hA55A;
      @(posedge ref_clk);
      pdo_wr <= 1'b0;
      mb_acc(1'b1, 1'b1, 9'h000, 16'h1234);
      mb_acc(1'b1, 1'b0, 9'h0FF, 16'h0000);
      mb_acc(1'b0, 1'b0, 9'h0FF, 16'h0000);
      check("input word FF", mb_rdata, 16'hA55A);
      mb_acc(1'b0, 1'b1, 9'h000, 16'h0000);
      check("holding word 0", mb_rdata, 16'h1234);
      check("in map", mb_err, 1'b0);
      @(posedge ref_clk);
      pdo_raddr <= 8'h00;
      @(posedge ref_clk);
      #1;
      check("pdo word 0", pdo_rdata, 16'h1234);
      mb_acc(1'b0, 1'b0, 9'h17F, 16'h0000);
      check("past node map", mb_err, 1'b1);
      $display("test words done");
   endtask
   task automatic t_nodes();
      mb_acc(1'b0, 1'b0, 9'h100, 16'h0000);
      check("no supervision", mb_err, 1'b1);
      @(posedge ref_clk);
      supervise_en <= 1'b1;
      mb_acc(1'b0, 1'b0, 9'h17E, 16'h0000);
      check("node 127 reset", mb_rdata, {cmbm_pkg::ST_PREOP, 8'h7F});
      node_state(7'd1, cmbm_pkg::ST_OPERATIONAL);
      node_state(7'd127, cmbm_pkg::ST_STOPPED);
      mb_acc(1'b0, 1'b0, 9'h100, 16'h0000);
      check("node 1 state", mb_rdata, {cmbm_pkg::ST_OPERATIONAL, 8'h01});
      mb_acc(1'b0, 1'b0, 9'h17E, 16'h0000);
      check("node 127 state", mb_rdata, {cmbm_pkg::ST_STOPPED, 8'h7F});
      $display("test nodes done");
   endtask
   task automatic t_nmt();
      logic [7:0] cmds [5];
      cmds = '{cmbm_pkg::CMD_START, cmbm_pkg::CMD_STOP, cmbm_pkg::CMD_PREOP,
         cmbm_pkg::CMD_RESET_NODE, cmbm_pkg::CMD_RESET_COMM};
      for (int i = 0; i < 5; i++) begin
         mb_acc(1'b1, 1'b1, 9'(9'h100 + i), {cmds[i], 8'(i + 1)});
         check("nmt pulse", nmt_valid, 1'b1);
         check("nmt cmd", nmt_cmd, {7'(i + 1), cmds[i]});
      end
      mb_acc(1'b1, 1'b1, 9'h17E, 16'h337F);
      check("no nmt", nmt_valid, 1'b0);
      mb_acc(1'b0, 1'b1, 9'h17E, 16'h0000);
      check("cmd slot", mb_rdata, 16'h337F);
      $display("test nmt done");
   endtask
   task automatic t_up();
      for (int i = 0; i < 4; i++) begin
         in_byte(9'(i), 8'(8'h11 * (i + 1)));
      end
      in_byte(9'h1FF, 8'hC3);
      sdo(8'h40, cmbm_pkg::OBJ_IN4, 8'h00, 32'h0, 4'h0, 8'h43, 32'h44332211);
      sdo(8'h40, 16'h2081, 8'h00, 32'h0, 4'h5, 8'h43, 32'h00004433);
      sdo(8'h40, 16'h237F, 8'h00, 32'h0, 4'h1, 8'h43, 32'h000000C3);
      $display("test upload done");
   endtask
   task automatic t_down();
      logic [8:0] ad [5];
      logic [7:0] ex [5];
      ad = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h009};
      ex = '{8'h01, 8'h02, 8'hEF, 8'hBE, 8'h5A};
      sdo(8'h23, cmbm_pkg::OBJ_OUT4, 8'h00, 32'h04030201, 4'h0, 8'h60, 32'h0);
      sdo(8'h23, 16'h3081, 8'h00, 32'h0000BEEF, 4'h2, 8'h60, 32'h0);
      sdo(8'h23, 16'h3189, 8'h00, 32'h0000005A, 4'h0, 8'h60, 32'h0);
      for (int i = 0; i < 5; i++) begin
         @(posedge ref_clk);
         out_raddr <= ad[i];
         @(posedge ref_clk);
         #1;
         check("out byte", out_rdata, ex[i]);
      end
      $display("test download done");
   endtask
   task automatic t_abort();
      sdo(8'h40, cmbm_pkg::OBJ_OUT4, 8'h00, 32'h0, 4'h0, 8'h80, cmbm_pkg::ABORT_WO);
      sdo(8'h23, cmbm_pkg::OBJ_IN4, 8'h00, 32'h0, 4'h0, 8'h80, cmbm_pkg::ABORT_RO);
      sdo(8'h40, 16'h2380, 8'h00, 32'h0, 4'h0, 8'h80, cmbm_pkg::ABORT_NO_OBJ);
      sdo(8'h40, cmbm_pkg::OBJ_IN4, 8'h01, 32'h0, 4'h0, 8'h80, cmbm_pkg::ABORT_NO_SUB);
      sdo(8'h55, cmbm_pkg::OBJ_IN4, 8'h00, 32'h0, 4'h0, 8'h80, cmbm_pkg::ABORT_CMD);
      $display("test abort done");
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Clock, watchdog and main sequence
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      failures++;
      end_sim();
   end
   initial begin
      {rst, supervise_en, mb_wr, mb_rd, mb_holding, pdo_wr, st_wr, in_wr, start} = 9'h100;
      {mb_addr, in_addr, out_raddr, mb_wdata, pdo_wdata} = '0;
      {pdo_waddr, pdo_raddr, st_state, in_wdata, st_node, delay} = '0;
      req_in = '0;
      rst = 1'b1;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      t_words();
      t_nodes();
      t_nmt();
      t_up();
      t_down();
      t_abort();
      end_sim();
   end
endmodule // test_canopen_modbus_buffer_map
